// >>> rtl/gsr_pkg.sv
package gsr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS     = 10;
  localparam int unsigned SETTLE_NS  = 2000;
  localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_MASK = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_RX   = 12'h00c;
  localparam logic [11:0] OFF_TX   = 12'h010;
  localparam logic [11:0] OFF_INFO = 12'h014;
  localparam logic [11:0] OFF_CMD  = 12'h018;

  // ----------------------------------------------------------------
  // Status byte layout and switch fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_NOREF  = 2;
  localparam int unsigned BIT_UNLOCK = 3;
  localparam int unsigned BIT_OVLD   = 4;
  localparam int unsigned BIT_AOFF   = 5;
  localparam int unsigned BIT_SRQ    = 6;
  localparam int unsigned BIT_CMDERR = 7;
  localparam logic [7:0]  SRQ_M      = 8'h40;
  localparam logic [7:0]  SELF_M     = 8'h3c;
  localparam int unsigned SW_ECHO    = 5;

  // ----------------------------------------------------------------
  // Bus commands, attention bytes with bit 7 dropped
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [1:0] GRP_LSN = 2'h1;
  localparam logic [1:0] GRP_TLK = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_IDLE, ACC_READY, ACC_WAIT} gsr_acc_e;
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_DAV, SRC_DONE} gsr_src_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gsr_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gsr_apb_rsp_s;

  typedef struct packed {
    logic [7:0] dio_n;
    logic       dav_n;
    logic       nrfd_n;
    logic       ndac_n;
    logic       eoi_n;
    logic       atn_n;
    logic       ifc_n;
  } gsr_gpib_in_s;

  typedef struct packed {
    logic [7:0] dio_n_o;
    logic [7:0] dio_n_oe;
    logic       dav_n_o;
    logic       dav_n_oe;
    logic       nrfd_n_o;
    logic       nrfd_n_oe;
    logic       ndac_n_o;
    logic       ndac_n_oe;
    logic       eoi_n_o;
    logic       eoi_n_oe;
    logic       srq_n_o;
    logic       srq_n_oe;
  } gsr_gpib_out_s;

  typedef struct packed {
    logic       valid;
    logic       dir;
    logic [7:0] data;
  } gsr_echo_s;

  typedef struct packed {
    gsr_acc_e    acc;
    gsr_src_e    src;
    logic        listen;
    logic        talk;
    logic        spoll;
    logic        remote;
    logic        rsv;
    logic [7:0]  mask;
    logic [7:0]  stat;
    logic [7:0]  pend;
    logic [7:0]  rx_data;
    logic        rx_eoi;
    logic        rx_valid;
    logic [7:0]  tx_data;
    logic        tx_eoi;
    logic        tx_valid;
    logic [15:0] cnt;
    logic [7:0]  dio_oe;
    logic        eoi_oe;
    logic        dav_oe;
    logic        nrfd_oe;
    logic        ndac_oe;
    gsr_echo_s   echo;
    logic [31:0] rdata;
    logic        dflt;
  } gsr_state_s;

  localparam gsr_state_s STATE_RST = '0;

endpackage

// >>> rtl/gsr_top.sv
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module gsr_top #(
  parameter logic [15:0] SETTLE = gsr_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input  logic                   pclk,
  input  logic                   presetn,
  // APB register port.
  input  gsr_pkg::gsr_apb_req_s  apb_req,
  output gsr_pkg::gsr_apb_rsp_s  apb_rsp,
  // Bus pins, open drain, wire levels in and enables out.
  input  gsr_pkg::gsr_gpib_in_s  gpib_i,
  output gsr_pkg::gsr_gpib_out_s gpib_o,
  // Configuration switches and instrument status events.
  input  logic [7:0]             bus_config_switch_bank,
  input  logic [7:0]             cond_i,
  // Serial echo channel.
  output gsr_pkg::gsr_echo_s     echo_o,
  input  logic                   echo_ready_i,
  // Instrument side controls.
  output logic                   remote_o,
  output logic                   default_reset_o
);
  import gsr_pkg::*;

  gsr_state_s  q;
  gsr_state_s  d;
  logic        atn;
  logic        dav;
  logic        nrfd_rel;
  logic        ndac_rel;
  logic        ifc;
  logic        echo_on;
  logic [4:0]  my_addr;
  logic [7:0]  bus_byte;
  logic [7:0]  set;
  logic [7:0]  hit;
  logic [7:0]  poll_byte;
  logic        act;
  logic        can_take;
  logic        src_ok;
  logic        poll_done;
  logic        clr_dev;
  logic        stat_rd;
  logic        freeze;
  logic        wr;
  logic        rd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Builds a talk or listen address from the group and switch address.
  function automatic logic [6:0] gsr_addr(input logic [1:0] grp, input logic [4:0] a);
    gsr_addr = {grp, a};
  endfunction

  // True for every offset that the register file decodes.
  function automatic logic gsr_mapped(input logic [11:0] a);
    gsr_mapped = (a == OFF_CTRL) || (a == OFF_MASK) || (a == OFF_STAT) ||
                 (a == OFF_RX) || (a == OFF_TX) || (a == OFF_INFO) || (a == OFF_CMD);
  endfunction

  // Bus lines are negative logic; turn them into asserted-true terms.
  assign atn      = ~gpib_i.atn_n;
  assign dav      = ~gpib_i.dav_n;
  assign ifc      = ~gpib_i.ifc_n;
  assign nrfd_rel = gpib_i.nrfd_n;
  assign ndac_rel = gpib_i.ndac_n;
  assign bus_byte = ~gpib_i.dio_n;
  assign my_addr  = bus_config_switch_bank[4:0];
  assign echo_on  = bus_config_switch_bank[SW_ECHO];

  // Conditions wired into their status positions; bit six is never a source.
  assign set = {cond_i[BIT_CMDERR], 1'b0, cond_i[BIT_AOFF], cond_i[BIT_OVLD],
                cond_i[BIT_UNLOCK], cond_i[BIT_NOREF], cond_i[1:0]};

  // The request flag rides in bit six of the polled byte only.
  assign poll_byte = q.stat | (q.rsv ? SRQ_M : 8'h00);
  assign hit       = q.stat & q.mask;

  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // All behaviour is computed here from the registered state copy.
  always_comb begin
    d         = q;
    d.dflt    = 1'b0;
    clr_dev   = 1'b0;
    stat_rd   = 1'b0;
    poll_done = 1'b0;
    act       = atn | q.listen;
    src_ok    = q.talk & ~atn;
    // Data bytes wait for an empty receive slot and a free echo slot.
    can_take  = atn | (~q.rx_valid & ~q.echo.valid);

    // Echo slot drains toward the serial side at its own pace.
    if (q.echo.valid && echo_ready_i) begin
      d.echo.valid = 1'b0;
    end

    // Read data is latched in the setup phase so prdata is a flop.
    if (apb_req.psel && !apb_req.penable) begin
      if (apb_req.paddr == OFF_CTRL) begin
        d.rdata = {31'h0, q.remote};
      end else if (apb_req.paddr == OFF_MASK) begin
        d.rdata = {24'h0, q.mask};
      end else if (apb_req.paddr == OFF_STAT) begin
        d.rdata = {24'h0, q.stat};
      end else if (apb_req.paddr == OFF_RX) begin
        d.rdata = {22'h0, q.rx_valid, q.rx_eoi, q.rx_data};
      end else if (apb_req.paddr == OFF_TX) begin
        d.rdata = {22'h0, q.tx_valid, q.tx_eoi, q.tx_data};
      end else if (apb_req.paddr == OFF_INFO) begin
        d.rdata = {16'h0, q.pend, 3'h0, echo_on, q.rsv, q.spoll, q.talk, q.listen};
      end else begin
        d.rdata = 32'h0;
      end
    end

    // Access phase writes; remote state is set only by software.
    if (wr) begin
      if (apb_req.paddr == OFF_CTRL) begin
        d.remote = apb_req.pwdata[0];
      end else if (apb_req.paddr == OFF_MASK) begin
        d.mask = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == OFF_TX) begin
        if (!q.tx_valid) begin
          d.tx_data  = apb_req.pwdata[7:0];
          d.tx_eoi   = apb_req.pwdata[8];
          d.tx_valid = 1'b1;
        end
      end else if (apb_req.paddr == OFF_CMD) begin
        clr_dev = apb_req.pwdata[0];
      end
    end

    // Access phase reads with side effects.
    if (rd) begin
      if (apb_req.paddr == OFF_STAT) begin
        stat_rd = 1'b1;
      end else if (apb_req.paddr == OFF_RX) begin
        d.rx_valid = 1'b0;
      end
    end

    // Acceptor handshake: ready, take the byte, hold until DAV drops.
    case (q.acc)
      ACC_IDLE: begin
        if (act && can_take && !dav) begin
          d.acc = ACC_READY;
        end
      end
      ACC_READY: begin
        if (!act || !can_take) begin
          d.acc = ACC_IDLE;
        end else if (dav) begin
          d.acc = ACC_WAIT;
          if (atn) begin
            // Attention bytes; REN, LLO, GTL and poll setup fall through.
            if (bus_byte[6:0] == gsr_addr(GRP_LSN, my_addr)) begin
              d.listen = 1'b1;
              d.talk   = 1'b0;
            end else if (bus_byte[6:0] == CMD_UNL) begin
              d.listen = 1'b0;
            end else if (bus_byte[6:0] == gsr_addr(GRP_TLK, my_addr)) begin
              d.talk   = 1'b1;
              d.listen = 1'b0;
            end else if (bus_byte[6:5] == GRP_TLK) begin
              d.talk = 1'b0;
            end else if (bus_byte[6:0] == CMD_DCL) begin
              clr_dev = 1'b1;
            end else if (bus_byte[6:0] == CMD_SDC && q.listen) begin
              clr_dev = 1'b1;
            end else if (bus_byte[6:0] == CMD_SPE) begin
              d.spoll = 1'b1;
            end else if (bus_byte[6:0] == CMD_SPD) begin
              d.spoll = 1'b0;
            end
          end else begin
            // Data goes to the command path whatever the remote state.
            d.rx_data  = bus_byte;
            d.rx_eoi   = ~gpib_i.eoi_n;
            d.rx_valid = 1'b1;
            if (echo_on) begin
              d.echo.valid = 1'b1;
              d.echo.dir   = 1'b0;
              d.echo.data  = bus_byte;
            end
          end
        end
      end
      ACC_WAIT: begin
        if (!dav || !act) begin
          d.acc = ACC_IDLE;
        end
      end
      default: begin
        d.acc = ACC_IDLE;
      end
    endcase

    // Acceptor lines follow the next state; with neither attention nor listen, neither line is driven.
    d.nrfd_oe = act & (d.acc != ACC_READY);
    d.ndac_oe = act & (d.acc != ACC_WAIT);

    // Source handshake; attention or loss of talk aborts at once.
    case (q.src)
      SRC_IDLE: begin
        if (src_ok && !q.echo.valid && (q.spoll || q.tx_valid)) begin
          // Poll byte goes out raw, not as decimal text.
          d.dio_oe = q.spoll ? poll_byte : q.tx_data;
          d.eoi_oe = ~q.spoll & q.tx_eoi;
          d.cnt    = SETTLE;
          d.src    = SRC_SETTLE;
        end
      end
      SRC_SETTLE: begin
        if (!src_ok) begin
          d.src = SRC_IDLE;
        end else if (q.cnt != 16'h0) begin
          d.cnt = q.cnt - 16'h1;
        end else if (nrfd_rel) begin
          d.dav_oe = 1'b1;
          d.src    = SRC_DAV;
          if (echo_on) begin
            d.echo.valid = 1'b1;
            d.echo.dir   = 1'b1;
            d.echo.data  = q.dio_oe;
          end
        end
      end
      SRC_DAV: begin
        if (!src_ok) begin
          d.src = SRC_IDLE;
        end else if (ndac_rel) begin
          d.src = SRC_DONE;
          if (q.spoll) begin
            poll_done = 1'b1;
          end else begin
            d.tx_valid = 1'b0;
          end
        end
      end
      SRC_DONE: begin
        // A poll answers once until attention returns.
        if (!q.spoll || atn || !q.talk) begin
          d.src = SRC_IDLE;
        end
      end
      default: begin
        d.src = SRC_IDLE;
      end
    endcase

    // Data and DAV are released whenever the source is not mid-byte.
    if (d.src == SRC_IDLE || d.src == SRC_DONE) begin
      d.dio_oe = 8'h00;
      d.eoi_oe = 1'b0;
      d.dav_oe = 1'b0;
    end

    // Status: sticky, frozen while a request or poll is outstanding.
    // New events win over any clear in the same cycle.
    freeze = q.rsv | (q.spoll & (q.src != SRC_IDLE));
    if (poll_done) begin
      d.stat = q.pend | set;
      d.pend = 8'h00;
      d.rsv  = 1'b0;
    end else if (freeze) begin
      d.pend = q.pend | set;
    end else begin
      d.stat = (stat_rd ? 8'h00 : q.stat) | set;
    end

    // Raise a request on any masked bit; sources in bits two to five drop their mask bit.
    if (!freeze && !poll_done && hit != 8'h00) begin
      d.rsv  = 1'b1;
      d.mask = d.mask & ~(hit & SELF_M);
    end

    // Device clear or software default reset; no lockout state exists.
    if (clr_dev) begin
      d.mask     = 8'h00;
      d.rx_valid = 1'b0;
      d.tx_valid = 1'b0;
      d.remote   = 1'b0;
      d.dflt     = 1'b1;
    end

    // Interface clear drops every addressed state.
    if (ifc) begin
      d.listen = 1'b0;
      d.talk   = 1'b0;
      d.spoll  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // The whole block state is one register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Zero wait state slave; unmapped offsets answer with an error.
  assign apb_rsp.prdata  = q.rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = rd | wr ? ~gsr_mapped(apb_req.paddr) : 1'b0;

  // Open drain pins only ever pull low, so the driven value is zero.
  assign gpib_o.dio_n_o   = 8'h00;
  assign gpib_o.dio_n_oe  = q.dio_oe;
  assign gpib_o.dav_n_o   = 1'b0;
  assign gpib_o.dav_n_oe  = q.dav_oe;
  assign gpib_o.nrfd_n_o  = 1'b0;
  assign gpib_o.nrfd_n_oe = q.nrfd_oe;
  assign gpib_o.ndac_n_o  = 1'b0;
  assign gpib_o.ndac_n_oe = q.ndac_oe;
  assign gpib_o.eoi_n_o   = 1'b0;
  assign gpib_o.eoi_n_oe  = q.eoi_oe;
  assign gpib_o.srq_n_o   = 1'b0;
  assign gpib_o.srq_n_oe  = q.rsv;

  assign echo_o          = q.echo;
  assign remote_o        = q.remote;
  assign default_reset_o = q.dflt;

endmodule

// >>> bench/gsr_chk.sv
`timescale 1ns/1ps
module gsr_chk #(
  parameter logic [15:0] SETTLE = gsr_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input logic                   pclk,
  input logic                   presetn,
  // Watched ports.
  input gsr_pkg::gsr_apb_req_s  apb_req,
  input gsr_pkg::gsr_gpib_in_s  gpib_i,
  input gsr_pkg::gsr_gpib_out_s gpib_o,
  input gsr_pkg::gsr_echo_s     echo_o,
  input logic                   echo_ready_i,
  input logic                   remote_o,
  input logic                   default_reset_o
);
  import gsr_pkg::*;
  localparam logic [15:0] SMIN = SETTLE - 16'h0001;
  logic [7:0]  dio_q;
  logic [15:0] st_q;
  logic        ctl_wr;
  logic        done;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----
  // Helpers
  // ----
  // A control write and the end of a sent byte, seen at the pins.
  assign ctl_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFF_CTRL;
  assign done   = gpib_o.dav_n_oe && gpib_i.ndac_n;
  // Counts how long the data lines have stood still; it saturates on long idles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_q <= 8'h00;
      st_q  <= 16'h0000;
    end else begin
      dio_q <= gpib_o.dio_n_oe;
      st_q  <= (gpib_o.dio_n_oe != dio_q) ? 16'h0000 : st_q + {15'h0000, ~&st_q};
    end
  end
  sequence s_ready_take;
    !gpib_o.nrfd_n_oe && gpib_o.ndac_n_oe && !gpib_i.dav_n;
  endsequence
  sequence s_accepted;
    gpib_o.nrfd_n_oe && !gpib_o.ndac_n_oe;
  endsequence
  sequence s_byte_done;
    done && gpib_i.atn_n;
  endsequence

  // ----
  // Assertions
  // ----
  a_no_ppoll: assert property (!gpib_i.atn_n [*2] |-> gpib_o.dio_n_oe == 8'h00)
    else $error("data lines driven under attention");
  a_dav_settle: assert property ($rose(gpib_o.dav_n_oe) |->
    st_q >= SMIN && $past(gpib_i.nrfd_n))
    else $error("data valid raised too early");
  a_dav_hold: assert property (gpib_o.dav_n_oe && !gpib_i.ndac_n && gpib_i.atn_n |=>
    gpib_o.dav_n_oe)
    else $error("data valid dropped before acceptance");
  a_dav_free: assert property (s_byte_done |=>
    !gpib_o.dav_n_oe && gpib_o.dio_n_oe == 8'h00)
    else $error("source lines not released");
  a_acc_take: assert property (s_ready_take |=> s_accepted)
    else $error("byte not accepted on data valid");
  a_acc_hold: assert property (s_accepted ##0 !gpib_i.dav_n |=> s_accepted)
    else $error("acceptance dropped while data valid");
  a_srq_drop: assert property ($fell(gpib_o.srq_n_oe) |->
    $past(done) || $past(done, 2))
    else $error("request released without a poll");
  a_echo_hold: assert property (echo_o.valid && !echo_ready_i |=>
    echo_o.valid && $stable(echo_o.data))
    else $error("echo character lost");
  a_remote_cause: assert property ($changed(remote_o) |->
    $past(ctl_wr) || $past(default_reset_o) || default_reset_o)
    else $error("remote state changed without a command");
endmodule

bind gsr_top gsr_chk #(.SETTLE(SETTLE)) i_gsr_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .gpib_i(gpib_i), .gpib_o(gpib_o),
  .echo_o(echo_o), .echo_ready_i(echo_ready_i), .remote_o(remote_o),
  .default_reset_o(default_reset_o)
);

// >>> bench/gsr_ctl_model.sv
`timescale 1ns/1ps
module gsr_ctl_model (
  // Clock.
  input  logic                   pclk,
  // Design enables in, wire levels out.
  input  gsr_pkg::gsr_gpib_out_s gpib_o,
  output gsr_pkg::gsr_gpib_in_s  gpib_i
);
  import gsr_pkg::*;
  logic [7:0] m_dio;
  logic       m_dav;
  logic       m_nrfd;
  logic       m_ndac;
  logic       m_eoi;
  logic       m_atn;
  logic [2:0] hs;

  // Open-drain wires: any enable pulls low, pull-ups otherwise; clear is never pulsed.
  assign gpib_i.dio_n  = ~(m_dio | gpib_o.dio_n_oe);
  assign gpib_i.dav_n  = ~(m_dav | gpib_o.dav_n_oe);
  assign gpib_i.nrfd_n = ~(m_nrfd | gpib_o.nrfd_n_oe);
  assign gpib_i.ndac_n = ~(m_ndac | gpib_o.ndac_n_oe);
  assign gpib_i.eoi_n  = ~(m_eoi | gpib_o.eoi_n_oe);
  assign gpib_i.atn_n  = ~m_atn;
  assign gpib_i.ifc_n  = 1'b1;
  assign hs = {gpib_i.dav_n, gpib_i.nrfd_n, gpib_i.ndac_n};

  // Everything released at time zero.
  initial begin
    {m_dio, m_dav, m_nrfd, m_ndac, m_eoi, m_atn} = '0;
  end

  // Waits for a handshake level at a rising edge; a hang ends the run.
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (hs[k] !== v && n < 5000);
    if (n >= 5000) tb.hang();
  endtask

  // Controller as source of attention and data bytes.
  task automatic send(input logic atn, input logic eoi, input logic [7:0] b);
    @(posedge pclk);
    m_atn <= atn;
    m_eoi <= eoi;
    m_dio <= b;
    wt(1, 1'b1);
    m_dav <= 1'b1;
    wt(0, 1'b1);
    m_dav <= 1'b0;
    m_dio <= 8'h00;
    m_eoi <= 1'b0;
  endtask

  // Controller as acceptor of a byte that the device talks.
  task automatic recv(output logic [7:0] b);
    @(posedge pclk);
    m_ndac <= 1'b1;
    m_atn  <= 1'b0;
    wt(2, 1'b0);
    b = ~gpib_i.dio_n;
    m_nrfd <= 1'b1;
    m_ndac <= 1'b0;
    wt(2, 1'b1);
    m_nrfd <= 1'b0;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import gsr_pkg::*;
  logic          pclk;
  logic          presetn;
  gsr_apb_req_s  apb_req;
  gsr_apb_rsp_s  apb_rsp;
  gsr_gpib_in_s  gpib_i;
  gsr_gpib_out_s gpib_o;
  logic [7:0]    sw;
  logic [7:0]    cond;
  gsr_echo_s     echo;
  logic          echo_rdy;
  logic          remote;
  logic          dflt;
  logic [4:0]    addr;
  logic [7:0]    d;
  logic [7:0]    rb;
  logic [32:0]   apb_q[$];
  logic [8:0]    echo_q[$];
  int            errors;
  int            samples_checked;
  int            dflt_n = 0;

  gsr_top #(.SETTLE(16'h0002)) i_gsr_top (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .gpib_i(gpib_i),
    .gpib_o(gpib_o), .bus_config_switch_bank(sw), .cond_i(cond), .echo_o(echo),
    .echo_ready_i(echo_rdy), .remote_o(remote), .default_reset_o(dflt)
  );
  gsr_ctl_model i_gsr_ctl_model (.pclk(pclk), .gpib_o(gpib_o), .gpib_i(gpib_i));

  // ----
  // Clock, serial side, scoreboard
  // ----
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The serial side stalls at random, so echo pacing is exercised while the echo switch is on.
  always @(posedge pclk) echo_rdy <= presetn ? 1'($urandom_range(0, 1)) : 1'b0;
  // Completed reads and taken echo characters meet the oldest note.
  always @(posedge pclk) begin
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
      chk("prdata", {apb_rsp.pslverr, apb_rsp.prdata},
          apb_q.size() > 0 ? apb_q.pop_front() : {33{1'bx}});
    end
    if (echo.valid === 1'b1 && echo_rdy === 1'b1) begin
      chk("echo", 33'({echo.dir, echo.data}),
          echo_q.size() > 0 ? 33'(echo_q.pop_front()) : {33{1'bx}});
    end
    // Default reset pulses are counted and compared once all clears are done.
    if (dflt === 1'b1) dflt_n++;
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    errors++;
    stop_test();
  endtask
  // One APB transfer; a read notes its expected {pslverr, prdata}.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, wd};
    if (!w) apb_q.push_back(e);
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    // The access ends at the first rising edge that sees pready high.
    do begin
      @(posedge pclk);
      if (++n > 50) hang();
    end while (apb_rsp.pready !== 1'b1);
    apb_req <= '0;
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge pclk);
    cond <= v;
    @(posedge pclk);
    cond <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic poll(input logic [7:0] e);
    logic [7:0] b;
    i_gsr_ctl_model.send(1'b1, 1'b0, {1'b0, CMD_SPE});
    i_gsr_ctl_model.send(1'b1, 1'b0, {3'h2, addr});
    i_gsr_ctl_model.recv(b);
    chk("poll_byte", 33'(b), 33'(e));
    i_gsr_ctl_model.send(1'b1, 1'b0, {1'b0, CMD_SPD});
    i_gsr_ctl_model.send(1'b1, 1'b0, 8'h5f);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(31));
    presetn = 1'b0;
    apb_req = '0;
    cond = 8'h00;
    errors = 0;
    samples_checked = 0;
    addr = 5'($urandom_range(1, 30));
    sw = {3'h0, addr};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("srq_line", 33'(gpib_o.srq_n_oe), 33'h0);
    d = 8'($urandom);
    apb(1'b1, OFF_MASK, 32'(d), 33'h0);
    apb(1'b0, OFF_MASK, 32'h0, 33'(d));
    apb(1'b0, 12'h100, 32'h0, 33'h100000000);
    // Request, self-masking, freeze, and a second request after the poll.
    apb(1'b1, OFF_MASK, 32'h90, 33'h0);
    ev(8'h10);
    chk("srq_line", 33'(gpib_o.srq_n_oe), 33'h1);
    apb(1'b0, OFF_MASK, 32'h0, 33'h80);
    ev(8'h88);
    apb(1'b0, OFF_INFO, 32'h0, 33'h8808);
    poll(8'h50);
    chk("srq_line", 33'(gpib_o.srq_n_oe), 33'h1);
    apb(1'b0, OFF_STAT, 32'h0, 33'h88);
    poll(8'hc8);
    chk("srq_line", 33'(gpib_o.srq_n_oe), 33'h0);
    apb(1'b0, OFF_STAT, 32'h0, 33'h0);
    ev(8'h03);
    apb(1'b0, OFF_STAT, 32'h0, 33'h3);
    apb(1'b0, OFF_STAT, 32'h0, 33'h0);
    // Listener, echo, and talk or listen addressing.
    sw <= {3'h1, addr};
    i_gsr_ctl_model.send(1'b1, 1'b0, {3'h1, addr});
    apb(1'b0, OFF_INFO, 32'h0, 33'h11);
    d = 8'($urandom);
    echo_q.push_back(9'(d));
    i_gsr_ctl_model.send(1'b0, 1'b1, d);
    apb(1'b0, OFF_RX, 32'h0, 33'h300 | 33'(d));
    i_gsr_ctl_model.send(1'b1, 1'b0, {3'h2, addr});
    apb(1'b0, OFF_INFO, 32'h0, 33'h12);
    // A talked data byte goes out intact and is echoed as sent.
    d = 8'($urandom);
    echo_q.push_back({1'b1, d});
    apb(1'b1, OFF_TX, {23'h0, 1'b1, d}, 33'h0);
    i_gsr_ctl_model.recv(rb);
    chk("talk_byte", 33'(rb), 33'(d));
    i_gsr_ctl_model.send(1'b1, 1'b0, {3'h1, addr});
    apb(1'b0, OFF_INFO, 32'h0, 33'h11);
    i_gsr_ctl_model.send(1'b1, 1'b0, {1'b0, CMD_UNL});
    chk("echo_left", 33'(echo_q.size()), 33'h0);
    sw <= {3'h0, addr};
    // Lockout messages are ignored; each clear path returns to defaults.
    apb(1'b1, OFF_CTRL, 32'h1, 33'h0);
    i_gsr_ctl_model.send(1'b1, 1'b0, 8'h11);
    i_gsr_ctl_model.send(1'b1, 1'b0, 8'h01);
    apb(1'b0, OFF_CTRL, 32'h0, 33'h1);
    chk("remote", 33'(remote), 33'h1);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFF_MASK, 32'hff, 33'h0);
      apb(1'b1, OFF_CTRL, 32'h1, 33'h0);
      i_gsr_ctl_model.send(1'b1, 1'b0, {3'h1, addr});
      if (k == 2) apb(1'b1, OFF_CMD, 32'h1, 33'h0);
      else i_gsr_ctl_model.send(1'b1, 1'b0, k ? {1'b0, CMD_SDC} : {1'b0, CMD_DCL});
      apb(1'b0, OFF_MASK, 32'h0, 33'h0);
      apb(1'b0, OFF_CTRL, 32'h0, 33'h0);
      chk("remote", 33'(remote), 33'h0);
    end
    chk("dflt_pulses", 33'(dflt_n), 33'h3);
    stop_test();
  end
endmodule
